// *** logic/etms_core.sv ***
// Epoch load, carrier test preload, time mark and measurement status logic
`timescale 1ns/1ps
`include "etms_defs.svh"
module etms_core #(
  parameter int NCH = 6
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              soft_reset_n,
  input  wire logic [NCH-1:0]    channel_hold_bit,
  input  wire logic              measurement_tick,
  input  wire logic [NCH-1:0]    immediate_mode,
  input  wire logic [NCH-1:0]    carrier_phase_accumulator_msb,
  input  wire logic [NCH-1:0]    new_data_ready,
  input  wire logic [NCH-1:0]    chip_slewing,
  input  wire logic              int_out,
  input  wire logic              int_in,
  input  wire logic              rtc_interrupt,
  input  wire logic              rtc_tick,
  input  wire logic [1:0]        mark_return_select,
  input  wire logic              mark_return_input_a,
  input  wire logic              mark_return_input_b,
  input  wire logic              mark_return_input_c,
  input  wire logic              tick_output,
  input  wire logic              tick_edge_falling,
  input  wire logic [7:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  output logic      [15:0]       rdata,
  output logic      [NCH-1:0]    counter_test_select,
  output logic      [NCH*18-1:0] carrier_cycle_count,
  output logic      [NCH*5-1:0]  short_epoch_count,
  output logic      [NCH*6-1:0]  long_epoch_count,
  output logic      [NCH-1:0]    chip_position_preset,
  output logic      [NCH-1:0]    protect_active,
  output logic      [20:0]       mark_count,
  output logic                   time_mark
);

  typedef struct packed {
    logic [1:0]         rst_sync;
    logic [5:0]         async_meta;
    logic [5:0]         async_sync;
    logic [5:0]         async_prev;
    logic [NCH-1:0]     test_sel;
    logic [NCH-1:0][17:0] carr;
    logic [NCH-1:0][4:0]  short_ep;
    logic [NCH-1:0][5:0]  long_ep;
    logic [NCH-1:0][4:0]  short_pend;
    logic [NCH-1:0][5:0]  long_pend;
    logic [NCH-1:0]     defer_armed;
    logic [NCH-1:0]     chip_preset;
    logic [NCH-1:0]     fresh_live;
    logic [NCH-1:0]     fresh_latched;
    logic [NCH-1:0]     protect;
    logic [NCH-1:0]     pending_read;
    logic [NCH-1:0]     lost_live;
    logic [NCH-1:0]     slew_live;
    logic [15:0]        stat_a;
    logic [15:0]        stat_b;
    logic               rtc_seen;
    logic               rtc_ack;
    logic               mark_ack;
    logic [4:0]         mark_hi;
    logic [15:0]        mark_lo;
    etms_pkg::etms_mark_t mk_state;
    logic [20:0]        mk_cnt;
    logic               mark_out;
    logic [15:0]        rdata;
  } etms_state_t;

  etms_state_t q;
  etms_state_t d;

  // Reset release synchroniser drives the whole block
  logic rst_n;
  assign rst_n = q.rst_sync[1];

  logic wr_lo_ch;
  logic [3:0] ch_ofs;
  logic [3:0] ch_idx;
  logic       hard_clear;
  logic [5:0] edge_now;
  logic       latch_now;
  logic       mark_ret;

  always_comb
  begin
    d = q;
    ch_ofs = addr[3:0];
    ch_idx = addr[7:4];
    wr_lo_ch = 1'b0;
    hard_clear = ~soft_reset_n;
    d.rst_sync = {q.rst_sync[0], 1'b1};
    // First stage of every pin synchroniser; only the second stage reads it
    d.async_meta[0] = int_in;
    d.async_meta[1] = int_out;
    d.async_meta[2] = rtc_interrupt;
    d.async_meta[3] = rtc_tick;
    d.async_meta[4] = (mark_return_select == 2'd0) ? mark_return_input_a :
                      (mark_return_select == 2'd1) ? mark_return_input_b :
                      (mark_return_select == 2'd2) ? mark_return_input_c : tick_output;
    d.async_meta[5] = 1'b0;
    d.async_sync = q.async_meta;
    d.async_prev = q.async_sync;
    edge_now = q.async_sync & ~q.async_prev;
    // Interrupt lines and the status latch strobe both capture the words
    latch_now = edge_now[1] | edge_now[0] | (wr_strobe && addr == `ETMS_ADR_STATUS_LATCH);
    // Mark return source: falling edge of the tick output when chosen that way
    mark_ret = (mark_return_select == 2'd3 && tick_edge_falling) ? (~q.async_sync[4] & q.async_prev[4])
                                                                 : edge_now[4];
    d.rdata = 16'h0000;

    for (int i = 0; i < NCH; i++)
    begin
      d.chip_preset[i] = 1'b0;
      d.fresh_live[i] = q.fresh_live[i] | new_data_ready[i];
      if (new_data_ready[i])
        d.protect[i] = 1'b1;
      if (wr_strobe && ch_idx == 4'(i))
      begin
        if (ch_ofs == `ETMS_OFS_TST_CYCLE && q.test_sel[i] && !carrier_phase_accumulator_msb[i])
          d.carr[i] = {wdata, 2'b00};
        if (ch_ofs == `ETMS_OFS_ACCUM_CLR && q.test_sel[i])
          d.chip_preset[i] = 1'b1;
        if (ch_ofs == `ETMS_OFS_MEAS_CLR)
        begin
          d.fresh_live[i] = new_data_ready[i];
          d.fresh_latched[i] = 1'b0;
          d.protect[i] = new_data_ready[i];
          d.lost_live[i] = 1'b0;
          d.slew_live[i] = 1'b0;
          d.stat_b[i] = 1'b0;
          d.stat_b[`ETMS_BIT_SLEW0+i] = 1'b0;
        end
      end
      if (wr_strobe && addr == `ETMS_ADR_TST_ALL && q.test_sel[i] && !carrier_phase_accumulator_msb[i])
        d.carr[i] = {wdata, 2'b00};
      // Epoch loads: channel i at a0 + 4*i (short) and a3 + 4*i (long), broadcast at the fixed addresses
      if (wr_strobe && (addr == `ETMS_ADR_SHORT_EP0 + 8'(4*i) || addr == `ETMS_ADR_SHORT_ALL))
      begin
        if (immediate_mode[i])
          d.short_ep[i] = wdata[4:0];
        else
          d.short_pend[i] = wdata[4:0];
      end
      if (wr_strobe && (addr == `ETMS_ADR_LONG_EP0 + 8'(4*i) || addr == `ETMS_ADR_LONG_ALL))
      begin
        d.test_sel[i] = wdata[`ETMS_BIT_TEST_SEL];
        if (immediate_mode[i])
          d.long_ep[i] = wdata[5:0];
        else
        begin
          d.long_pend[i] = wdata[5:0];
          d.defer_armed[i] = 1'b1;
        end
      end
      if (measurement_tick && q.defer_armed[i])
      begin
        d.short_ep[i] = q.short_pend[i];
        d.long_ep[i] = q.long_pend[i];
        d.defer_armed[i] = 1'b0;
      end
      // Readout end releases protection unless newer data came in since the latch
      if (rd_strobe && ch_idx == 4'(i) && ch_ofs == `ETMS_OFS_CARR_READ)
      begin
        d.fresh_latched[i] = 1'b0;
        if (!q.pending_read[i])
        begin
          d.fresh_live[i] = new_data_ready[i];
          d.protect[i] = new_data_ready[i];
        end
      end
      d.pending_read[i] = (q.pending_read[i] | (new_data_ready[i] & q.fresh_latched[i])) & ~latch_now;
      if (measurement_tick)
      begin
        if (q.protect[i] && q.fresh_live[i])
          d.lost_live[i] = 1'b1;
        if (!q.protect[i])
          d.slew_live[i] = chip_slewing[i];
      end
      if (latch_now)
      begin
        d.fresh_latched[i] = q.fresh_live[i];
        d.stat_a[i] = q.fresh_live[i];
        d.stat_b[i] = q.lost_live[i];
        d.stat_b[`ETMS_BIT_SLEW0+i] = q.slew_live[i];
      end
      else
        d.stat_a[i] = q.fresh_latched[i] & d.fresh_latched[i];
      // Hold bit low or software reset clears channel state; registers remain usable
      if (!channel_hold_bit[i] || hard_clear)
      begin
        d.carr[i] = 18'h00000;
        d.short_ep[i] = 5'h00;
        d.long_ep[i] = 6'h00;
        d.defer_armed[i] = 1'b0;
        d.fresh_live[i] = 1'b0;
        d.fresh_latched[i] = 1'b0;
        d.stat_a[i] = 1'b0;
        d.protect[i] = 1'b0;
        d.pending_read[i] = 1'b0;
        d.lost_live[i] = 1'b0;
        d.slew_live[i] = 1'b0;
        d.stat_b[i] = 1'b0;
        d.stat_b[`ETMS_BIT_SLEW0+i] = 1'b0;
      end
      if (hard_clear)
        d.test_sel[i] = 1'b0;
    end

    // Real time clock acknowledge: interrupt then following clock tick
    if (edge_now[2])
      d.rtc_seen = 1'b1;
    if (edge_now[3] && q.rtc_seen)
    begin
      d.rtc_ack = 1'b1;
      d.rtc_seen = 1'b0;
    end
    else if ((rd_strobe && addr == `ETMS_ADR_RTC_DELAY) || (wr_strobe && addr == `ETMS_ADR_ALL_MEAS_CLR))
      d.rtc_ack = 1'b0;
    if (mark_ret)
      d.mark_ack = 1'b1;
    else if ((rd_strobe && addr == `ETMS_ADR_MARK_HI) || (wr_strobe && addr == `ETMS_ADR_ALL_MEAS_CLR))
      d.mark_ack = 1'b0;
    // Both acknowledge flags ignore software reset
    d.stat_a[`ETMS_BIT_MARK_ACK] = q.mark_ack;
    d.stat_a[`ETMS_BIT_RTC_ACK] = q.rtc_ack;

    // Time mark generator
    d.mark_out = 1'b0;
    if (wr_strobe && addr == `ETMS_ADR_MARK_HI)
      d.mark_hi = wdata[4:0];
    if (wr_strobe && addr == `ETMS_ADR_MARK_LO)
    begin
      d.mark_lo = wdata;
      wr_lo_ch = 1'b1;
    end
    case (q.mk_state)
      etms_pkg::ETMS_MK_IDLE:
        if (wr_lo_ch)
          d.mk_state = etms_pkg::ETMS_MK_ARMED;
      etms_pkg::ETMS_MK_ARMED:
        if (measurement_tick)
        begin
          d.mk_cnt = {q.mark_hi, q.mark_lo};
          d.mk_state = etms_pkg::ETMS_MK_COUNT;
        end
      etms_pkg::ETMS_MK_COUNT:
        if (q.mk_cnt == 21'h000000)
        begin
          d.mark_out = 1'b1;
          d.mk_state = wr_lo_ch ? etms_pkg::ETMS_MK_ARMED : etms_pkg::ETMS_MK_IDLE;
        end
        else
        begin
          d.mk_cnt = q.mk_cnt - 21'(`ETMS_STEP_CYC);
          // A new low word write restarts the generator for the next tick
          if (wr_lo_ch)
            d.mk_state = etms_pkg::ETMS_MK_ARMED;
        end
      default:
        d.mk_state = etms_pkg::ETMS_MK_IDLE;
    endcase

    if (rd_strobe && addr == `ETMS_ADR_STATUS_A)
      d.rdata = q.stat_a;
    else if (rd_strobe && addr == `ETMS_ADR_STATUS_B)
      d.rdata = q.stat_b;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else if (!rst_n)
    begin
      q <= '0;
      q.rst_sync <= {q.rst_sync[0], 1'b1};
    end
    else
      q <= d;
  end

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      carrier_cycle_count[i*18 +: 18] = q.carr[i];
      short_epoch_count[i*5 +: 5] = q.short_ep[i];
      long_epoch_count[i*6 +: 6] = q.long_ep[i];
    end
  end

  assign rdata = q.rdata;
  assign counter_test_select = q.test_sel;
  assign chip_position_preset = q.chip_preset;
  assign protect_active = q.protect;
  assign mark_count = q.mk_cnt;
  assign time_mark = q.mark_out;

endmodule : etms_core

// *** logic/etms_defs.svh ***
// Register offsets, field positions and timing counts for the epoch, time mark and measurement status block
`ifndef ETMS_DEFS_SVH
`define ETMS_DEFS_SVH
`define ETMS_CH_STRIDE        8'h10
`define ETMS_OFS_TST_CYCLE    4'h7
`define ETMS_ADR_TST_ALL      8'h77
`define ETMS_ADR_STATUS_A     8'h80
`define ETMS_ADR_STATUS_B     8'h81
`define ETMS_ADR_SHORT_EP0    8'ha0
`define ETMS_ADR_LONG_EP0     8'ha3
`define ETMS_ADR_SHORT_ALL    8'hbc
`define ETMS_ADR_LONG_ALL     8'hbf
`define ETMS_ADR_MARK_HI      8'hc3
`define ETMS_ADR_MARK_LO      8'hc4
`define ETMS_ADR_RTC_DELAY    8'hc2
`define ETMS_ADR_STATUS_LATCH 8'hc6
`define ETMS_ADR_ALL_MEAS_CLR 8'hc7
`define ETMS_OFS_ACCUM_CLR    4'h8
`define ETMS_OFS_MEAS_CLR     4'h9
`define ETMS_OFS_CARR_READ    4'ha
`define ETMS_BIT_TEST_SEL     6
`define ETMS_BIT_MARK_ACK     14
`define ETMS_BIT_RTC_ACK      15
`define ETMS_BIT_SLEW0        8
`define ETMS_CHIP_LAST        10'h3ff
`define ETMS_STEP_NS          50
`define ETMS_CLK_NS           50
`define ETMS_STEP_CYC         ((`ETMS_STEP_NS + `ETMS_CLK_NS - 1) / `ETMS_CLK_NS)
`endif

// *** logic/etms_pkg.sv ***
// Types for the epoch, time mark and measurement status block
package etms_pkg;
  typedef enum logic [1:0] {
    ETMS_MK_IDLE,
    ETMS_MK_ARMED,
    ETMS_MK_COUNT
  } etms_mark_t;
endpackage : etms_pkg

// *** testbench/etms_core_props.sv ***
// Concurrent checks on the epoch, time mark and status block ports
`timescale 1ns/1ps
module etms_core_props #(
  parameter int NCH = 6
) (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              soft_reset_n,
  input wire logic [NCH-1:0]    channel_hold_bit,
  input wire logic              measurement_tick,
  input wire logic [NCH-1:0]    immediate_mode,
  input wire logic [NCH-1:0]    carrier_phase_accumulator_msb,
  input wire logic [7:0]        addr,
  input wire logic [15:0]       wdata,
  input wire logic              wr_strobe,
  input wire logic              rd_strobe,
  input wire logic [15:0]       rdata,
  input wire logic [NCH-1:0]    counter_test_select,
  input wire logic [NCH*18-1:0] carrier_cycle_count,
  input wire logic [NCH*5-1:0]  short_epoch_count,
  input wire logic [NCH*6-1:0]  long_epoch_count,
  input wire logic [NCH-1:0]    chip_position_preset,
  input wire logic              time_mark
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ok0;
  logic wok;
  assign ok0 = soft_reset_n && channel_hold_bit[0] && !measurement_tick;
  assign wok = counter_test_select[0] && !carrier_phase_accumulator_msb[0];
  AST_RST_SEL: assert property ($rose(arst_n) |-> counter_test_select == '0)
    else $error("test select not clear after reset");
  AST_PRE_REFUSE: assert property (wr_strobe && addr == 8'h07 && ok0 && !wok
    |=> $stable(carrier_cycle_count[17:0])) else $error("refused preload changed counter");
  AST_PRE_LOAD: assert property (wr_strobe && addr == 8'h07 && ok0 && wok
    |=> carrier_cycle_count[17:0] == {$past(wdata), 2'b00}) else $error("preload value wrong");
  AST_BCAST_SKIP: assert property (wr_strobe && addr == 8'h77 && !counter_test_select[1]
    && soft_reset_n && channel_hold_bit[1] |=> $stable(carrier_cycle_count[35:18])) else $error("broadcast hit channel");
  AST_SHORT_NOW: assert property (wr_strobe && addr == 8'ha0 && immediate_mode[0] && ok0
    |=> short_epoch_count[4:0] == $past(wdata[4:0])) else $error("short epoch not loaded");
  AST_LONG_NOW: assert property (wr_strobe && addr == 8'ha3 && immediate_mode[0] && ok0
    |=> {counter_test_select[0], long_epoch_count[5:0]} == $past(wdata[6:0])) else $error("long epoch not loaded");
  AST_DEFER: assert property (wr_strobe && addr == 8'ha7 && !immediate_mode[1] && !measurement_tick
    |=> $stable(long_epoch_count[11:6])) else $error("deferred load applied early");
  AST_CHIP_SET: assert property (wr_strobe && addr == 8'h08 && ok0
    |=> chip_position_preset[0] == $past(counter_test_select[0])) else $error("chip preset wrong");
  AST_MARK_PULSE: assert property (time_mark |=> !time_mark)
    else $error("time mark longer than one cycle");
  AST_RD_ZERO: assert property (rd_strobe && addr != 8'h80 && addr != 8'h81 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  cover property (wr_strobe && addr == 8'h07 && wok);
  cover property (time_mark);
  cover property (chip_position_preset[0]);
endmodule : etms_core_props
bind etms_core etms_core_props #(.NCH(NCH)) u_props (.clk(clk), .arst_n(arst_n), .soft_reset_n(soft_reset_n),
  .channel_hold_bit(channel_hold_bit), .measurement_tick(measurement_tick), .immediate_mode(immediate_mode),
  .carrier_phase_accumulator_msb(carrier_phase_accumulator_msb), .addr(addr), .wdata(wdata),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .counter_test_select(counter_test_select),
  .carrier_cycle_count(carrier_cycle_count), .short_epoch_count(short_epoch_count),
  .long_epoch_count(long_epoch_count), .chip_position_preset(chip_position_preset), .time_mark(time_mark));

// *** testbench/etms_host.sv ***
// Host processor model issuing register writes and reads
`timescale 1ns/1ps
module etms_host (
  input  wire logic        clk,
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr_strobe,
  output logic             rd_strobe,
  input  wire logic [15:0] rdata
);
  initial
  begin
    addr = 8'hff;
    wdata = 16'h0000;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
    // Released lines carry no stale value
    addr = ~a;
    wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd_strobe = 1'b1;
    @(negedge clk);
    d = rdata;
    rd_strobe = 1'b0;
    addr = ~a;
  endtask : rd
endmodule : etms_host

// *** testbench/tb_top.sv ***
// Directed testbench for the epoch, time mark and status block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, arst_n = 1'b0, srst_n = 1'b1, tick = 1'b0, int_o = 1'b0, rtc_i = 1'b0, rtc_t = 1'b0, mk_b = 1'b0;
  logic [5:0] hold_n = 6'h3f, imm = 6'h3d, msb = 6'h00, nd = 6'h00, slew = 6'h00;
  logic int_i = 1'b0;
  logic [1:0] msel = 2'h1;
  logic [15:0] rv;
  logic found;
  wire logic [7:0] addr;
  wire logic [15:0] wdata, rdata;
  wire logic wr_s, rd_s, tm;
  wire logic [5:0] sel, pre;
  wire logic [107:0] carr;
  wire logic [29:0] sh;
  wire logic [35:0] lg;
  wire logic [20:0] mcnt;
  int failures = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  etms_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr_strobe(wr_s), .rd_strobe(rd_s), .rdata(rdata));
  etms_core #(.NCH(6)) u_dut (.clk(clk), .arst_n(arst_n), .soft_reset_n(srst_n), .channel_hold_bit(hold_n),
    .measurement_tick(tick), .immediate_mode(imm), .carrier_phase_accumulator_msb(msb), .new_data_ready(nd),
    .chip_slewing(slew), .int_out(int_o), .int_in(int_i), .rtc_interrupt(rtc_i), .rtc_tick(rtc_t),
    .mark_return_select(msel), .mark_return_input_a(1'b0), .mark_return_input_b(mk_b), .mark_return_input_c(1'b0),
    .tick_output(1'b0), .tick_edge_falling(1'b0), .addr(addr), .wdata(wdata), .wr_strobe(wr_s), .rd_strobe(rd_s),
    .rdata(rdata), .counter_test_select(sel), .carrier_cycle_count(carr), .short_epoch_count(sh),
    .long_epoch_count(lg), .chip_position_preset(pre), .protect_active(), .mark_count(mcnt), .time_mark(tm));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    u_host.rd(a, rv);
    chk({20'h0, rv}, {20'h0, e});
  endtask : rdc
  task automatic lt;
    u_host.wr(8'hc6, 16'h0000);
  endtask : lt
  task automatic tk;
    w(1);
    tick = 1'b1;
    w(1);
    tick = 1'b0;
  endtask : tk
  task automatic ndp(input int c);
    w(1);
    nd[c] = 1'b1;
    w(1);
    nd = 6'h00;
  endtask : ndp
  task automatic test_done;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  initial
  begin
    #200000;
    failures++;
    test_done;
  end
  initial
  begin
    w(5);
    arst_n = 1'b1;
    w(3);
    chk(sel, 6'h00);
    rdc(8'h80, 16'h0000);
    rdc(8'h81, 16'h0000);
    u_host.wr(8'ha3, 16'hff71);
    chk({sel[0], lg[5:0]}, {1'b1, 6'h31});
    u_host.wr(8'ha0, 16'hffd3);
    chk(sh[4:0], 5'h13);
    u_host.wr(8'ha4, 16'h0005);
    u_host.wr(8'ha7, 16'h0007);
    chk({sh[9:5], lg[11:6]}, 11'h000);
    tk;
    w(2);
    chk({sh[9:5], lg[11:6]}, {5'h05, 6'h07});
    u_host.wr(8'h07, 16'habcd);
    chk(carr[17:0], 18'h2af34);
    msb[0] = 1'b1;
    u_host.wr(8'h07, 16'h1111);
    chk(carr[17:0], 18'h2af34);
    msb[0] = 1'b0;
    u_host.wr(8'h77, 16'h1234);
    chk(carr[35:0], {18'h0, 18'h048d0});
    u_host.wr(8'h08, 16'h0000);
    chk(pre, 6'h01);
    ndp(2);
    lt;
    rdc(8'h80, 16'h0004);
    u_host.wr(8'h29, 16'hffff);
    lt;
    rdc(8'h80, 16'h0000);
    ndp(2);
    lt;
    u_host.rd(8'h2a, rv);
    lt;
    rdc(8'h80, 16'h0000);
    ndp(3);
    tk;
    w(2);
    tk;
    w(2);
    lt;
    rdc(8'h81, 16'h0008);
    hold_n[3] = 1'b0;
    w(2);
    lt;
    rdc(8'h81, 16'h0000);
    hold_n[3] = 1'b1;
    slew[4] = 1'b1;
    tk;
    w(2);
    lt;
    rdc(8'h81, 16'h1000);
    slew[4] = 1'b0;
    u_host.wr(8'h49, 16'h0000);
    lt;
    rdc(8'h81, 16'h0000);
    ndp(5);
    int_o = 1'b1;
    w(5);
    int_o = 1'b0;
    rdc(8'h80, 16'h0020);
    u_host.wr(8'h59, 16'h0000);
    w(2);
    int_i = 1'b1;
    w(5);
    int_i = 1'b0;
    rdc(8'h80, 16'h0000);
    u_host.wr(8'h59, 16'h0000);
    rtc_i = 1'b1;
    w(4);
    rtc_i = 1'b0;
    w(4);
    rtc_t = 1'b1;
    w(4);
    rtc_t = 1'b0;
    w(4);
    srst_n = 1'b0;
    w(2);
    srst_n = 1'b1;
    w(2);
    chk(sel, 6'h00);
    lt;
    rdc(8'h80, 16'h8000);
    u_host.rd(8'hc2, rv);
    lt;
    rdc(8'h80, 16'h0000);
    mk_b = 1'b1;
    w(4);
    mk_b = 1'b0;
    w(4);
    lt;
    rdc(8'h80, 16'h4000);
    u_host.wr(8'hc7, 16'h0000);
    lt;
    rdc(8'h80, 16'h0000);
    u_host.wr(8'hc3, 16'h0001);
    u_host.wr(8'hc4, 16'h0002);
    tk;
    found = 1'b0;
    repeat (4)
    begin
      if (mcnt === 21'h010002) found = 1'b1;
      w(1);
    end
    chk(found, 1'b1);
    u_host.wr(8'hc3, 16'h0000);
    u_host.wr(8'hc4, 16'h0004);
    tk;
    found = 1'b0;
    repeat (12)
    begin
      w(1);
      if (tm === 1'b1) found = 1'b1;
    end
    chk(found, 1'b1);
    test_done;
  end
endmodule : tb_top
